//--- design/fsbr_device.sv
// flash end: read configuration, burst sequencing and wait generation
`default_nettype none
module fsbr_device #(
	parameter int ADDR_W = 24
) (
	input  wire logic                ref_clk,
	input  wire logic                rstn,
	input  wire logic                clkEn,
	fsbr_if.device                   link,
	output logic [fsbr_pkg::CFG_W-1:0] readConfig,
	output logic                     burstActive
);
	import fsbr_pkg::*;

	localparam int SW = 6 + ADDR_W + 16;

	function automatic logic [4:0] burst_words(input logic [2:0] bl);
		case (bl)
			BL_4:    burst_words = 5'h04;
			BL_8:    burst_words = 5'h08;
			BL_16:   burst_words = 5'h10;
			default: burst_words = 5'h00;
		endcase
	endfunction : burst_words

	logic [SW-1:0]     pinS;
	logic              lclkS;
	logic              ceNS;
	logic              oeNS;
	logic              weNS;
	logic              advNS;
	logic              rstFS;
	logic [ADDR_W-1:0] addrS;
	logic [15:0]       hostDqS;

	fsbr_sync #(.W(SW)) u_pin_sync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.clkEn   (clkEn),
		.asyncIn ({link.linkClk, link.ceN, link.oeN, link.weN, link.advN,
			link.rstFlashN, link.addr, link.hostDq}),
		.syncOut (pinS)
	);
	assign {lclkS, ceNS, oeNS, weNS, advNS, rstFS, addrS, hostDqS} = pinS;

	fsbr_dstate_t      state_q;
	logic [15:0]       cfg_q;
	logic [15:0]       cur_q;
	logic              idMode_q;
	logic              lclk_q;
	logic              weN_q;
	logic [ADDR_W-1:0] addr_q;
	logic [1:0]        startLow_q;
	logic              rowDone_q;
	logic [3:0]        gap_q;
	logic [1:0]        hold_q;
	logic [4:0]        words_q;
	logic [15:0]       dq_q;
	logic              wait_q;

	// the burst runs on the settings captured at its start
	wire               useCur     = (state_q != DS_IDLE);
	wire  [15:0]       actCfg     = useCur ? cur_q : cfg_q;
	wire               riseE      = lclkS & ~lclk_q;
	wire               fallE      = ~lclkS & lclk_q;
	wire               selEdge    = actCfg[CE_BIT] ? riseE : fallE;
	wire               busActive  = ~ceNS & ~oeNS & rstFS;
	wire               weDone     = weNS & ~weN_q & ~ceNS & rstFS;
	wire               asyncMode  = cfg_q[RM_BIT];
	wire               startBurst = busActive & ~advNS & selEdge & ~asyncMode;
	wire  [2:0]        lc         = cur_q[LC_LSB +: 3];
	wire               dh         = cur_q[DH_BIT];
	wire               bw         = cur_q[BW_BIT];
	wire  [4:0]        lenW       = burst_words(cur_q[BL_LSB +: 3]);
	wire  [1:0]        cycLen     = dh ? 2'h2 : 2'h1;
	wire  [4:0]        wordsN     = words_q + 5'h01;
	wire  [3:0]        lcm1       = {1'b0, lc} - 4'h1;

	// next word address: wrap inside the aligned group or run on linearly
	wire  [ADDR_W-1:0] grpMask    = (lenW == 5'h00 || bw) ? '1 : ADDR_W'(lenW - 5'h01);
	wire  [ADDR_W-1:0] addrInc    = addr_q + ADDR_W'(1);
	wire  [ADDR_W-1:0] nextAddr   = idMode_q ? addr_q :
		((addr_q & ~grpMask) | (addrInc & grpMask));
	wire               lastWord   = (lenW == 5'h00) ? (&addr_q) : (wordsN == lenW);

	// codes above four need extra clocks every fourth word at one-clock hold
	wire  [3:0]        quadWait   = (wordsN[1:0] == 2'h0 && !dh && lc > LC_NO_WAIT) ?
		({1'b0, lc} - {1'b0, LC_NO_WAIT}) : 4'h0;
	wire               crossRow   = bw & ~rowDone_q & (nextAddr[3:0] == 4'h0) &
		(startLow_q != 2'h0) & ~idMode_q;
	wire  [3:0]        rowDelay   = (startLow_q == 2'h3 || {2'b00, startLow_q} >= lcm1) ?
		lcm1 : {2'b00, startLow_q};
	wire  [3:0]        extraGap   = quadWait + (crossRow ? rowDelay : 4'h0);

	function automatic logic [15:0] word_at(input logic [ADDR_W-1:0] a, input logic id,
		input logic [15:0] cfg);
		if (id)
			word_at = (a[7:0] == ID_CFG_OFFSET) ? cfg : 16'h0000;
		else
			word_at = ARRAY_SEED ^ a[15:0];
	endfunction : word_at

	// wait asserted while no data is valid; early release covers one data cycle
	wire               stallPh    = (state_q == DS_LAT) || (state_q == DS_GAP);
	// early release must also flag a gap that follows the word now on the bus
	wire               dataStall  = (state_q == DS_DATA) & ~lastWord &
		(({2'b00, cycLen} - {2'b00, hold_q}) < extraGap);
	wire               waitNext   = cur_q[WD_BIT] ?
		((stallPh & (gap_q > {2'b00, cycLen})) | dataStall) : stallPh;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			lclk_q <= 1'b0;
			weN_q  <= 1'b1;
		end else if (clkEn) begin
			lclk_q <= lclkS;
			weN_q  <= weNS;
		end
	end

	// configuration and command writes land when the write strobe rises with chip enable low
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_q    <= CFG_RESET;
			idMode_q <= 1'b0;
		end else if (clkEn && weDone) begin
			if (hostDqS[7:0] == CMD_CFG)
				cfg_q <= addrS[15:0];
			else if (hostDqS[7:0] == CMD_ID)
				idMode_q <= 1'b1;
			else if (hostDqS[7:0] == CMD_ARRAY)
				idMode_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q    <= DS_IDLE;
			cur_q      <= CFG_RESET;
			addr_q     <= '0;
			startLow_q <= 2'h0;
			rowDone_q  <= 1'b0;
			gap_q      <= 4'h0;
			hold_q     <= 2'h0;
			words_q    <= 5'h00;
		end else if (clkEn) begin
			if (!busActive) begin
				state_q <= DS_IDLE;
			end else if (startBurst && (state_q == DS_IDLE || state_q == DS_DONE)) begin
				state_q    <= DS_LAT;
				cur_q      <= cfg_q;
				addr_q     <= addrS;
				startLow_q <= addrS[1:0];
				rowDone_q  <= 1'b0;
				gap_q      <= {1'b0, cfg_q[LC_LSB +: 3]};
				words_q    <= 5'h00;
			end else if (selEdge) begin
				case (state_q)
					DS_LAT, DS_GAP: begin
						if (gap_q <= 4'h1) begin
							state_q <= DS_DATA;
							hold_q  <= cycLen;
						end else begin
							gap_q <= gap_q - 4'h1;
						end
					end
					DS_DATA: begin
						if (hold_q > 2'h1) begin
							hold_q <= hold_q - 2'h1;
						end else if (lastWord) begin
							state_q <= DS_DONE;
						end else begin
							words_q   <= wordsN;
							addr_q    <= nextAddr;
							rowDone_q <= rowDone_q | crossRow;
							hold_q    <= cycLen;
							if (extraGap != 4'h0) begin
								state_q <= DS_GAP;
								gap_q   <= extraGap;
							end
						end
					end
					DS_DONE: state_q <= DS_DONE;
					default: state_q <= DS_IDLE;
				endcase
			end
		end
	end

	// data: async reads follow the address, sync words only change on edges
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			dq_q <= 16'h0000;
		end else if (clkEn) begin
			if (busActive && asyncMode && state_q == DS_IDLE)
				dq_q <= word_at(addrS, idMode_q, cfg_q);
			else if (state_q == DS_DATA || (stallPh && selEdge && gap_q <= 4'h1))
				dq_q <= word_at(addr_q, idMode_q, cur_q);
		end
	end

	// while the bus is active, state only steps on selected edges, so wait follows one clock behind them
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wait_q <= 1'b0;
		end else if (clkEn) begin
			if (!busActive)
				wait_q <= 1'b0;
			else
				wait_q <= waitNext;
		end
	end

	assign link.devDq   = dq_q;
	assign link.devDqOe = busActive;
	assign link.waitOut = actCfg[WP_BIT] ? wait_q : ~wait_q;
	assign link.waitOe  = busActive;
	assign readConfig   = cfg_q;
	assign burstActive  = useCur;
endmodule : fsbr_device
`default_nettype wire

//--- design/fsbr_host.sv
// controller end: link clock divider, read and write cycles, avalon register port
`default_nettype none
module fsbr_host #(
	parameter int ADDR_W = 24
) (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        clkEn,
	fsbr_if.host             link,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest
);
	import fsbr_pkg::*;

	logic [17:0]       devS;
	fsbr_sync #(.W(18)) u_dev_sync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.clkEn   (clkEn),
		.asyncIn ({link.devDq, link.waitOut, link.waitOe}),
		.syncOut (devS)
	);

	fsbr_hstate_t      state_q;
	logic [15:0]       cfg_q;
	logic [ADDR_W-1:0] addr_q;
	logic [7:0]        len_q;
	logic [7:0]        cnt_q;
	logic [15:0]       data_q;
	logic [7:0]        cmd_q;
	logic [1:0]        op_q;
	logic              go_q;
	logic              ack_q;
	logic [7:0]        div_q;
	logic              lclk_q;
	logic [1:0]        hist_q;
	logic [1:0]        phase_q;
	logic [7:0]        tmr_q;
	logic [31:0]       rdata_q;

	wire        tick     = (div_q == 8'(LINK_HALF_CYC - 1));
	wire        hRise    = tick & ~lclk_q;
	wire        access   = (avs_read | avs_write) & ~ack_q;
	// a write lands only at the edge where waitrequest is seen low
	wire        wrAcc    = avs_write & ack_q;
	wire        waitDeas = (devS[1] != cfg_q[WP_BIT]) & devS[0];
	// early release means the word arrives one data cycle after wait drops
	wire        takeNow  = ~cfg_q[WD_BIT] ? waitDeas :
		(cfg_q[DH_BIT] ? hist_q[1] : hist_q[0]);
	wire [1:0]  cycLen   = cfg_q[DH_BIT] ? 2'h2 : 2'h1;
	wire [15:0] cfgClean = (avs_writedata[15:0] & ~CFG_RSVD_MASK) |
		(16'h0001 << BS_BIT);
	// a queued operation already counts as busy, or a status poll could miss it
	wire        busy     = (state_q != HS_IDLE) || go_q;

	assign avs_waitrequest = access;
	assign avs_readdata    = rdata_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			div_q  <= 8'h00;
			lclk_q <= 1'b0;
			ack_q  <= 1'b0;
		end else if (clkEn) begin
			div_q  <= tick ? 8'h00 : div_q + 8'h01;
			lclk_q <= lclk_q ^ tick;
			ack_q  <= access;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 32'h0000_0000;
		end else if (clkEn && avs_read && !ack_q) begin
			case (avs_address)
				REG_ADDR:   rdata_q <= 32'(addr_q);
				REG_CFG:    rdata_q <= {16'h0000, cfg_q};
				REG_STATUS: rdata_q <= {16'h0000, cnt_q, 7'h00, busy};
				REG_DATA:   rdata_q <= {16'h0000, data_q};
				default:    rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= HS_IDLE;
			cfg_q   <= CFG_RESET;
			addr_q  <= '0;
			len_q   <= 8'h01;
			cnt_q   <= 8'h00;
			data_q  <= 16'h0000;
			cmd_q   <= 8'h00;
			op_q    <= 2'h0;
			go_q    <= 1'b0;
			hist_q  <= 2'h0;
			phase_q <= 2'h0;
			tmr_q   <= 8'h00;
		end else if (clkEn) begin
			if (wrAcc && avs_address == REG_ADDR)
				addr_q <= avs_writedata[ADDR_W-1:0];
			if (wrAcc && avs_address == REG_CTRL && !busy) begin
				op_q  <= avs_writedata[1:0];
				cmd_q <= avs_writedata[15:8];
				len_q <= avs_writedata[23:16];
				go_q  <= (avs_writedata[1:0] != 2'h0);
			end
			if (wrAcc && avs_address == REG_CFG && !busy) begin
				cfg_q <= cfgClean;
				cmd_q <= CMD_CFG;
				op_q  <= OP_CFG;
				go_q  <= 1'b1;
			end
			if (state_q == HS_ASYNC && tmr_q != 8'h00)
				tmr_q <= tmr_q - 8'h01;
			else if (state_q == HS_ASYNC) begin
				data_q  <= devS[17:2];
				cnt_q   <= 8'h01;
				state_q <= HS_END;
			end
			if (hRise) begin
				hist_q <= {hist_q[0], waitDeas};
				case (state_q)
					HS_IDLE: begin
						if (go_q) begin
							go_q   <= 1'b0;
							cnt_q  <= 8'h00;
							hist_q <= 2'h0;
							phase_q <= 2'h0;
							tmr_q  <= 8'(ASYNC_CYC);
							if (op_q == OP_READ)
								state_q <= cfg_q[RM_BIT] ? HS_ASYNC : HS_ADV;
							else
								state_q <= HS_WRITE;
						end
					end
					HS_ADV: begin
						// wait seen before the start edge qualifies no word
						state_q <= HS_BURST;
						hist_q  <= 2'h0;
					end
					HS_BURST: begin
						// one capture per data cycle; later end-of-line waits are not trusted
						if (takeNow && phase_q == 2'h0) begin
							data_q  <= devS[17:2];
							cnt_q   <= cnt_q + 8'h01;
							phase_q <= cycLen - 2'h1;
							if (cnt_q + 8'h01 >= len_q)
								state_q <= HS_END;
						end else if (phase_q != 2'h0) begin
							phase_q <= phase_q - 2'h1;
						end
					end
					HS_WRITE: state_q <= HS_END;
					HS_ASYNC: state_q <= HS_ASYNC;
					HS_END:   state_q <= HS_IDLE;
					default:  state_q <= HS_IDLE;
				endcase
			end
		end
	end

	wire rdCyc = (state_q == HS_ADV) || (state_q == HS_BURST) || (state_q == HS_ASYNC);
	wire wrCyc = (state_q == HS_WRITE);
	// chip enable, address and data outlast the write strobe so the flash latches them
	wire wrTail = (state_q == HS_END) && (op_q != OP_READ);

	assign link.linkClk   = lclk_q;
	assign link.ceN       = ~(rdCyc | wrCyc | wrTail);
	assign link.oeN       = ~rdCyc;
	assign link.weN       = ~wrCyc;
	assign link.advN      = ~((state_q == HS_ADV) | (state_q == HS_ASYNC));
	assign link.rstFlashN = rstn;
	assign link.addr      = ((wrCyc || wrTail) && op_q == OP_CFG) ? ADDR_W'(cfg_q) : addr_q;
	assign link.hostDq    = {8'h00, cmd_q};
	assign link.hostDqOe  = wrCyc | wrTail;
endmodule : fsbr_host
`default_nettype wire

//--- design/fsbr_if.sv
// pin bundle between the flash end and the controller end
`default_nettype none
interface fsbr_if #(parameter int ADDR_W = 24);
	logic              linkClk;
	logic              ceN;
	logic              oeN;
	logic              weN;
	logic              advN;
	logic              rstFlashN;
	logic [ADDR_W-1:0] addr;
	logic [15:0]       hostDq;
	logic              hostDqOe;
	logic [15:0]       devDq;
	logic              devDqOe;
	logic              waitOut;
	logic              waitOe;

	modport device (
		input  linkClk, ceN, oeN, weN, advN, rstFlashN, addr, hostDq, hostDqOe,
		output devDq, devDqOe, waitOut, waitOe
	);
	modport host (
		output linkClk, ceN, oeN, weN, advN, rstFlashN, addr, hostDq, hostDqOe,
		input  devDq, devDqOe, waitOut, waitOe
	);
endinterface : fsbr_if
`default_nettype wire

//--- design/fsbr_pkg.sv
// shared constants and types for the synchronous burst read link
`default_nettype none
package fsbr_pkg;
	localparam int            CFG_W         = 16;
	localparam int            RM_BIT        = 15;
	localparam int            LC_LSB        = 11;
	localparam int            WP_BIT        = 10;
	localparam int            DH_BIT        = 9;
	localparam int            WD_BIT        = 8;
	localparam int            BS_BIT        = 7;
	localparam int            CE_BIT        = 6;
	localparam int            BW_BIT        = 3;
	localparam int            BL_LSB        = 0;
	localparam logic [15:0]   CFG_RESET     = 16'hbfcf;
	localparam logic [15:0]   CFG_RSVD_MASK = 16'h4030;
	localparam logic [2:0]    BL_4          = 3'h1;
	localparam logic [2:0]    BL_8          = 3'h2;
	localparam logic [2:0]    BL_16         = 3'h3;
	localparam logic [2:0]    BL_CONT       = 3'h7;
	localparam logic [2:0]    LC_NO_WAIT    = 3'h4;
	localparam logic [7:0]    CMD_CFG       = 8'h60;
	localparam logic [7:0]    CMD_ID        = 8'h90;
	localparam logic [7:0]    CMD_ARRAY     = 8'hff;
	localparam logic [7:0]    ID_CFG_OFFSET = 8'h05;
	localparam logic [15:0]   ARRAY_SEED    = 16'h5a00;
	localparam logic [4:0]    REG_CTRL      = 5'h00;
	localparam logic [4:0]    REG_ADDR      = 5'h04;
	localparam logic [4:0]    REG_CFG       = 5'h08;
	localparam logic [4:0]    REG_STATUS    = 5'h0c;
	localparam logic [4:0]    REG_DATA      = 5'h10;
	localparam logic [1:0]    OP_READ       = 2'h1;
	localparam logic [1:0]    OP_CFG        = 2'h2;
	localparam logic [1:0]    OP_CMD        = 2'h3;
	localparam int            REF_PERIOD_NS = 50;
	localparam int            LINK_PERIOD_NS = 400;
	localparam int            LINK_HALF_CYC = LINK_PERIOD_NS / REF_PERIOD_NS / 2;
	localparam int            ASYNC_ACC_NS  = 300;
	localparam int            ASYNC_CYC     = (ASYNC_ACC_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

	typedef enum logic [2:0] {
		DS_IDLE = 3'b000,
		DS_LAT  = 3'b001,
		DS_DATA = 3'b010,
		DS_GAP  = 3'b011,
		DS_DONE = 3'b100
	} fsbr_dstate_t;

	typedef enum logic [2:0] {
		HS_IDLE  = 3'b000,
		HS_ADV   = 3'b001,
		HS_BURST = 3'b010,
		HS_ASYNC = 3'b011,
		HS_WRITE = 3'b100,
		HS_END   = 3'b101
	} fsbr_hstate_t;
endpackage : fsbr_pkg
`default_nettype wire

//--- design/fsbr_sync.sv
// two-stage synchroniser for a bundle of pin inputs
`default_nettype none
module fsbr_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	input  wire logic         clkEn,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);
	logic [W-1:0] meta_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			meta_q  <= '0;
			syncOut <= '0;
		end else if (clkEn) begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule : fsbr_sync
`default_nettype wire

//--- tb/flash_sync_burst_read_config_bench.sv
// self-checking bench: avalon register accesses drive the controller against the flash end
`default_nettype none
module flash_sync_burst_read_config_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import fsbr_pkg::*;

	typedef struct packed {
		logic       rm;
		logic [2:0] lc;
		logic       wp, dh, wd, ce, bw;
		logic [2:0] bl;
		logic [7:0] start, n;
	} fsbr_case_t;

	logic        ref_clk = 1'b0;
	logic        rstn    = 1'b0;
	logic        clkEn   = 1'b1;
	logic [4:0]  avAddr  = 5'h00;
	logic        avRead  = 1'b0;
	logic        avWrite = 1'b0;
	logic [31:0] avWdata = 32'h0;
	logic [31:0] avRdata;
	logic        avWait;
	logic [15:0] devCfg;
	logic        devBusy;
	int          error_cnt  = 0;
	int          num_checks = 0;
	// the slow link clock suits every latency code and one-clock hold
	fsbr_case_t  cases [9] = '{
		'{1'h1, 3'h7, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, BL_CONT, 8'h03, 8'h01},
		'{1'h0, 3'h4, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, BL_4, 8'h01, 8'h04},
		'{1'h0, 3'h4, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, BL_4, 8'h01, 8'h04},
		'{1'h0, 3'h6, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, BL_8, 8'h05, 8'h08},
		'{1'h0, 3'h7, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, BL_16, 8'h0e, 8'h10},
		'{1'h0, 3'h5, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, BL_16, 8'h03, 8'h10},
		'{1'h0, 3'h3, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, BL_CONT, 8'h0d, 8'h06},
		'{1'h0, 3'h2, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, BL_4, 8'h02, 8'h04},
		'{1'h1, 3'h7, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, BL_CONT, 8'h05, 8'h01}
	};

	always #25 ref_clk = ~ref_clk;

	fsbr_if #(.ADDR_W(24)) link ();
	fsbr_device #(.ADDR_W(24)) u_fsbr_device (.ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn),
		.link(link), .readConfig(devCfg), .burstActive(devBusy));
	fsbr_host #(.ADDR_W(24)) u_fsbr_host (.ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn),
		.link(link), .avs_address(avAddr), .avs_read(avRead), .avs_write(avWrite),
		.avs_writedata(avWdata), .avs_readdata(avRdata), .avs_waitrequest(avWait));
	fsbr_checker #(.ADDR_W(24)) u_fsbr_checker (.ref_clk(ref_clk), .rstn(rstn),
		.linkClk(link.linkClk), .ceN(link.ceN), .oeN(link.oeN), .weN(link.weN),
		.advN(link.advN), .addr(link.addr), .hostDq(link.hostDq), .devDq(link.devDq),
		.devDqOe(link.devDqOe), .waitOut(link.waitOut), .waitOe(link.waitOe));

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	task automatic fail_out;
		error_cnt++;
		results();
	endtask : fail_out

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// the request stands until waitrequest is seen low at a rising edge; data is taken there
	task automatic av_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge ref_clk);
		avAddr  <= a;
		avWdata <= d;
		avWrite <= wr;
		avRead  <= !wr;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avWait !== 1'b0 && n < 50);
		if (n >= 50) fail_out();
		q = avRdata;
		avWrite <= 1'b0;
		avRead  <= 1'b0;
	endtask : av_xfer

	task automatic do_op(input logic [4:0] r, input logic [31:0] d, output logic [31:0] s);
		int k;
		av_xfer(1'h1, r, d, s);
		k = 0;
		do begin
			av_xfer(1'h0, REG_STATUS, 32'h0, s);
			k++;
		end while (s[0] !== 1'b0 && k < 500);
		if (k >= 500) fail_out();
	endtask : do_op

	function automatic logic [15:0] exp_word(input fsbr_case_t c);
		logic [7:0] len;
		logic [7:0] a;
		len = (c.bl == BL_CONT || c.rm) ? 8'h00 : 8'h04 << (c.bl - 3'h1);
		a = c.start + c.n - 8'h01;
		if (len != 8'h00 && !c.bw) a = (c.start & ~(len - 8'h01)) | (a & (len - 8'h01));
		exp_word = ARRAY_SEED ^ {8'h00, a};
	endfunction : exp_word

	initial begin
		fsbr_case_t  c;
		logic [15:0] cfg;
		logic [31:0] s;
		logic [31:0] q;
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		check({16'h0, devCfg}, {16'h0, CFG_RESET});
		av_xfer(1'h0, 5'h14, 32'h0, q);
		check(q, 32'h0);
		foreach (cases[i]) begin
			c = cases[i];
			cfg = {c.rm, 1'h0, c.lc, c.wp, c.dh, c.wd, 1'h1, c.ce, 2'h0, c.bw, c.bl};
			check({31'h0, devBusy}, 32'h0);
			// reserved bits set and the BS_BIT bit cleared on purpose: the controller must clean them
			do_op(REG_CFG, {16'h0, cfg ^ 16'h40b0}, s);
			check({16'h0, devCfg}, {16'h0, cfg});
			av_xfer(1'h0, REG_CFG, 32'h0, q);
			check({16'h0, q[15:0]}, {16'h0, cfg});
			av_xfer(1'h1, REG_ADDR, {24'h0, c.start}, q);
			do_op(REG_CTRL, {8'h0, c.n, 8'h0, 6'h0, OP_READ}, s);
			av_xfer(1'h0, REG_DATA, 32'h0, q);
			check(q, {16'h0, exp_word(c)});
			if (!c.rm) check({24'h0, s[15:8]}, {24'h0, c.n});
			do_op(REG_CTRL, {16'h0, CMD_ID, 6'h0, OP_CMD}, s);
			av_xfer(1'h1, REG_ADDR, {24'h0, ID_CFG_OFFSET}, q);
			do_op(REG_CTRL, {8'h0, c.n, 8'h0, 6'h0, OP_READ}, s);
			av_xfer(1'h0, REG_DATA, 32'h0, q);
			check(q, {16'h0, cfg});
			do_op(REG_CTRL, {16'h0, CMD_ARRAY, 6'h0, OP_CMD}, s);
			$display("test %0d done", i);
		end
		results();
	end
endmodule : flash_sync_burst_read_config_bench
`default_nettype wire

//--- tb/fsbr_checker.sv
// pin-level checks on the flash link: enables, wait timing, first access and data hold
`default_nettype none
module fsbr_checker #(
	parameter int ADDR_W = 24
) (
	input wire logic              ref_clk,
	input wire logic              rstn,
	input wire logic              linkClk,
	input wire logic              ceN,
	input wire logic              oeN,
	input wire logic              weN,
	input wire logic              advN,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [15:0]       hostDq,
	input wire logic [15:0]       devDq,
	input wire logic              devDqOe,
	input wire logic              waitOut,
	input wire logic              waitOe
);
	import fsbr_pkg::*;
	logic [15:0] cfg_q;
	logic [15:0] adr_q;
	logic [15:0] dq_q;
	logic [7:0]  cmd_q;
	logic [7:0]  edgeCnt_q;
	logic [7:0]  lastChg_q;
	logic [3:0]  edgeAge_q;
	logic        link_q;
	logic        we_q;
	logic        act_q;
	logic        rel_q;
	logic        seen_q;
	wire  [2:0]  lc       = cfg_q[LC_LSB +: 3];
	wire  [7:0]  cyc      = cfg_q[DH_BIT] ? 8'h02 : 8'h01;
	wire  [7:0]  relEdge  = {5'h0, lc} - (cfg_q[WD_BIT] ? cyc : 8'h00);
	wire         syncRd   = !cfg_q[RM_BIT] && waitOe;
	wire         selEdge  = cfg_q[CE_BIT] ? (linkClk && !link_q) : (!linkClk && link_q);
	wire         waitAct  = waitOut == cfg_q[WP_BIT];
	wire         chg      = devDq != dq_q;
	wire         burstOff = ceN || !advN;
	// wrapped fixed bursts with no periodic gaps: words must come at an even pace
	wire         flat     = !cfg_q[BW_BIT] && cfg_q[2:0] != BL_CONT
	                        && (cfg_q[DH_BIT] || lc == LC_NO_WAIT);

	// shadow of the configuration as the device should have stored it
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_q <= CFG_RESET;
			adr_q <= 16'h0;
			cmd_q <= 8'h0;
			we_q  <= 1'b1;
		end else begin
			we_q <= weN;
			if (!weN && !ceN) begin
				adr_q <= addr[15:0];
				cmd_q <= hostDq[7:0];
			end
			if (weN && !we_q && cmd_q == CMD_CFG) begin
				cfg_q <= adr_q;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			link_q    <= 1'b0;
			dq_q      <= 16'h0;
			edgeAge_q <= 4'hf;
			edgeCnt_q <= 8'h0;
			lastChg_q <= 8'h0;
			act_q     <= 1'b0;
			rel_q     <= 1'b0;
			seen_q    <= 1'b0;
		end else begin
			link_q    <= linkClk;
			dq_q      <= devDq;
			edgeAge_q <= selEdge ? 4'h0 : edgeAge_q + {3'h0, edgeAge_q != 4'hf};
			edgeCnt_q <= burstOff ? 8'h00 : edgeCnt_q + {7'h0, selEdge};
			act_q     <= !burstOff && (act_q || (syncRd && waitAct));
			rel_q     <= !burstOff && (rel_q || (act_q && syncRd && !waitAct));
			seen_q    <= !burstOff && (seen_q || (syncRd && chg));
			if (chg) begin
				lastChg_q <= edgeCnt_q;
			end
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	a_oe_pair: assert property (waitOe == devDqOe)
		else $error("wait enable differs from data enable");
	a_float_off: assert property ((ceN || oeN) [*5] |-> !waitOe && !devDqOe)
		else $error("outputs driven outside a read cycle");
	// the opposite link edge lands four ref cycles away, so a move from it shows age 7 or more
	a_wait_edge: assert property ((!ceN && !oeN) [*5] ##0 ($changed(waitOut) && waitOe
		&& $past(waitOe)) |-> edgeAge_q < 4'h7)
		else $error("wait moved away from a selected link edge");
	a_async_idle: assert property (cfg_q[RM_BIT] && waitOe |-> !waitAct)
		else $error("wait asserted in an async read");
	a_wait_level: assert property (syncRd && !ceN && edgeCnt_q == 8'h02 && lc >= 3'h6
		|-> waitAct)
		else $error("wait not asserted during latency");
	a_first_data: assert property (syncRd && $past(waitOe) && act_q && !rel_q && $fell(waitAct)
		|-> edgeCnt_q + 8'h01 >= relEdge && edgeCnt_q <= relEdge + 8'h01)
		else $error("first wait release at wrong edge count");
	a_hold_cycle: assert property (syncRd && $past(waitOe) && !ceN && !oeN && flat && seen_q
		&& chg |-> edgeCnt_q - lastChg_q == cyc)
		else $error("data word held for wrong number of edges");
	a_no_gap: assert property (syncRd && $past(waitOe) && !ceN && !oeN && flat && rel_q
		|-> !waitAct)
		else $error("wait state inserted where none is due");

	c_release: cover property (syncRd && act_q && $fell(waitAct));
	c_gap: cover property (syncRd && lc == 3'h7 && !cfg_q[DH_BIT] && rel_q && waitAct);
	c_fall_edge: cover property (!cfg_q[CE_BIT] && syncRd && rel_q);
endmodule : fsbr_checker
`default_nettype wire
